// *** crcu_consts.svh ***
// Purpose: Constants for the checksum calculation unit
// Assumes: Included by crcu_pkg.sv and crcu_top.sv
// Notes:   Definitions only
`ifndef CRCU_CONSTS_SVH
`define CRCU_CONSTS_SVH

// ****************************************
// Generator polynomials
// ****************************************
`define CRCU_POLY_16     32'h0000_8005
`define CRCU_POLY_CCITT  32'h0000_1021
`define CRCU_POLY_32     32'h04C1_1DB7

// ****************************************
// Mode and size encodings
// ****************************************
`define CRCU_MODE_16     2'h0
`define CRCU_MODE_CCITT  2'h1
`define CRCU_MODE_32     2'h2
`define CRCU_SIZE_BYTE   2'h0
`define CRCU_SIZE_HALF   2'h1
`define CRCU_SIZE_WORD   2'h2

// ****************************************
// Widths, masks, counts, reset values
// ****************************************
`define CRCU_DATA_W      32
`define CRCU_FIFO_DEPTH  16
`define CRCU_MASK16      32'h0000_FFFF
`define CRCU_MASK32      32'hFFFF_FFFF
`define CRCU_CRC_RST     32'h0000_0000
`define CRCU_BYTES_BYTE  3'h1
`define CRCU_BYTES_HALF  3'h2
`define CRCU_BYTES_WORD  3'h4

`endif

// *** crcu_pkg.sv ***
// Purpose: Types for the checksum calculation unit
// Assumes: crcu_consts.svh holds the numbers
// Notes:   Carrier structs and state encoding
`include "crcu_consts.svh"

package crcu_pkg;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [1:0] mode;
		logic       din_cmpl;
		logic       din_byte_rev;
		logic       din_bit_rev;
		logic       sum_cmpl;
		logic       sum_byte_rev;
		logic       sum_bit_rev;
	} crcu_cfg_t;

	typedef struct packed {
		logic [1:0]             size;
		logic [`CRCU_DATA_W-1:0] data;
	} crcu_wr_t;

	// ****************************************
	// Engine states
	// ****************************************
	typedef enum logic [1:0] {
		CRCU_ST_IDLE = 2'b01,
		CRCU_ST_FOLD = 2'b10
	} crcu_state_t;

endpackage

// *** crcu_top.sv ***
// Purpose: Checksum calculation unit with input FIFO and byte-serial fold engine
// Assumes: Writer and configuration logic run on clk_sys; no synchronisers needed
// Notes:   One line per rule below, tag first
// Functional notes
// - Offer 16-bit mode with polynomial 0x8005.
// - Offer CCITT 16-bit mode with polynomial 0x1021.
// - Offer 32-bit mode with polynomial 0x04C11DB7.
// - Complement, byte and bit reversal selectable for data and result separately.
// - Byte, half-word and word writes fold exactly their byte count.
// - Accumulator seed is loadable before a computation.
// - A byte folds in one cycle, a word in four cycles.
// - Consecutive DMA writes accepted in order; DMA supplies ordered data.
// - Result is 16 bits wide in 16-bit modes, 32 in 32-bit mode.
`timescale 1ns/10ps
`include "crcu_consts.svh"

// ****************************************
// Input FIFO
// ****************************************
module crcu_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr_ff;
	logic [AW-1:0]    rptr_ff;
	logic [CW-1:0]    count_ff;
	wire              push;
	wire              pull;

	// Handshake decode; full and empty come straight from the count
	assign in_ready  = (count_ff != CW'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign push      = in_valid && in_ready;
	assign pull      = out_valid && out_ready;
	assign out_data  = mem[rptr_ff];

	// Storage has no reset; only valid entries are ever read
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wptr_ff] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wptr_ff  <= '0;
			rptr_ff  <= '0;
			count_ff <= '0;
		end else begin
			wptr_ff  <= push ? wptr_ff + AW'(1) : wptr_ff;
			rptr_ff  <= pull ? rptr_ff + AW'(1) : rptr_ff;
			count_ff <= count_ff + CW'(push) - CW'(pull);
		end
	end

	default clocking cb_fifo @(posedge clk_sys); endclocking
	default disable iff (reset);

	// Count moves by exactly one per lone push or pull, and never past full
	a_fifo_push_count: assert property (
		(push && !pull) |=> (count_ff == $past(count_ff) + CW'(1)))
		else $error("FIFO count did not grow on push");
	a_fifo_pop_count: assert property (
		(pull && !push) |=> (count_ff == $past(count_ff) - CW'(1)))
		else $error("FIFO count did not shrink on pull");
	a_fifo_full_stall: assert property (
		(count_ff == CW'(DEPTH)) |=> (count_ff == CW'(DEPTH) - CW'($past(pull))))
		else $error("FIFO accepted data while full");
	c_fifo_full: cover property (count_ff == CW'(DEPTH));
endmodule

// ****************************************
// Checksum unit top
// ****************************************
module crcu_top import crcu_pkg::*; (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    reset,
	// Configuration
	input  wire crcu_cfg_t               cfg,
	// Seed load
	input  wire logic                    seed_load,
	input  wire logic [`CRCU_DATA_W-1:0] seed_value,
	// Data write stream
	input  wire logic                    wr_valid,
	output logic                         wr_ready,
	input  wire crcu_wr_t                wr_req,
	// Result and status
	output logic [`CRCU_DATA_W-1:0]      crc_result,
	output logic                         busy
);
	// Engine state, byte shift register, accumulator and result
	crcu_state_t  state_ff;
	crcu_state_t  nxt_state;
	logic [2:0]   left_ff;
	logic [2:0]   nxt_left;
	logic [31:0]  sh_ff;
	logic [31:0]  nxt_sh;
	logic [31:0]  crc_ff;
	logic [31:0]  nxt_crc;
	logic [31:0]  result_ff;
	logic [31:0]  nxt_result;
	crcu_wr_t     fifo_q;
	logic         fifo_valid;

	// ****************************************
	// Byte fold, MSB-first shift register form
	// ****************************************
	function automatic logic [31:0] crc_fold(input logic [31:0] crc, input logic [7:0] din,
	                                         input logic [31:0] poly, input logic wide);
		logic [31:0] c;
		logic        fb;
		c  = crc;
		fb = 1'b0;
		for (int i = 0; i < 8; i++) begin
			fb = (wide ? c[31] : c[15]) ^ din[7-i];
			c  = {c[30:0], 1'b0} ^ (fb ? poly : 32'h0000_0000);
		end
		return wide ? c : (c & `CRCU_MASK16);
	endfunction

	// ****************************************
	// Input FIFO, back-pressure reaches wr_ready
	// ****************************************
	wire pop;
	crcu_fifo #(
		.WIDTH ($bits(crcu_wr_t)),
		.DEPTH (`CRCU_FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_req),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_q)
	);

	// Mode decode; the unused code 2'h3 behaves as 32-bit
	wire        is32    = cfg.mode[1];
	wire [31:0] poly    = is32 ? `CRCU_POLY_32 :
	                      (cfg.mode == `CRCU_MODE_CCITT) ? `CRCU_POLY_CCITT :
	                      `CRCU_POLY_16;
	wire [31:0] wmask   = is32 ? `CRCU_MASK32 : `CRCU_MASK16;
	wire        is_byte = (fifo_q.size == `CRCU_SIZE_BYTE);
	wire        is_half = (fifo_q.size == `CRCU_SIZE_HALF);
	wire [2:0]  n_bytes = is_byte ? `CRCU_BYTES_BYTE :
	                      is_half ? `CRCU_BYTES_HALF : `CRCU_BYTES_WORD;

	// Engine takes a new entry only when idle, so earlier input is never overrun
	assign pop  = fifo_valid && (state_ff == CRCU_ST_IDLE);
	assign busy = (state_ff == CRCU_ST_FOLD) || fifo_valid;

	// ****************************************
	// Data preprocessing: complement, byte swap, bit swap
	// ****************************************
	wire [31:0] din_c    = cfg.din_cmpl ? ~fifo_q.data : fifo_q.data;
	wire [31:0] din_half = {din_c[31:16], din_c[7:0], din_c[15:8]};
	wire [31:0] din_word = {din_c[7:0], din_c[15:8], din_c[23:16], din_c[31:24]};
	wire [31:0] din_r    = (!cfg.din_byte_rev || is_byte) ? din_c :
	                       is_half ? din_half : din_word;
	wire [31:0] din_b;

	// ****************************************
	// Result postprocessing
	// ****************************************
	wire [31:0] res_c  = (cfg.sum_cmpl ? ~crc_ff : crc_ff) & wmask;
	wire [31:0] res_sw = is32 ? {res_c[7:0], res_c[15:8], res_c[23:16], res_c[31:24]} :
	                     {16'h0000, res_c[7:0], res_c[15:8]};
	wire [31:0] res_r  = cfg.sum_byte_rev ? res_sw : res_c;
	wire [31:0] rev32;
	wire [31:0] rev16;

	// Per-bit swaps: data reversed within each byte, result across its width
	for (genvar i = 0; i < 32; i++) begin : g_bits
		assign din_b[i] = cfg.din_bit_rev ? din_r[(i & ~7) | (7 - (i & 7))] : din_r[i];
		assign rev32[i] = res_r[31-i];
		assign rev16[i] = (i < 16) ? res_r[(15 - i) & 15] : 1'b0;
	end
	assign nxt_result = cfg.sum_bit_rev ? (is32 ? rev32 : rev16) : res_r;
	assign crc_result = result_ff;

	// ****************************************
	// Fold engine: one byte per cycle, low byte first
	// ****************************************
	wire [31:0] crc_step = crc_fold(crc_ff, sh_ff[7:0], poly, is32);

	// Next state; a seed load overrides any fold in the same cycle
	always_comb begin
		nxt_state = state_ff;
		nxt_left  = left_ff;
		nxt_sh    = sh_ff;
		nxt_crc   = crc_ff;
		unique case (state_ff)
			CRCU_ST_IDLE: begin
				if (pop) begin
					nxt_state = CRCU_ST_FOLD;
					nxt_left  = n_bytes;
					nxt_sh    = din_b;
				end
			end
			CRCU_ST_FOLD: begin
				nxt_crc  = crc_step;
				nxt_sh   = {8'h00, sh_ff[31:8]};
				nxt_left = left_ff - 3'h1;
				if (left_ff == 3'h1) begin
					nxt_state = CRCU_ST_IDLE;
				end
			end
		endcase
		if (seed_load) begin
			nxt_crc = seed_value & wmask;
		end
	end

	// Engine registers
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_ff  <= CRCU_ST_IDLE;
			left_ff   <= 3'h0;
			sh_ff     <= 32'h0000_0000;
			crc_ff    <= `CRCU_CRC_RST;
			result_ff <= 32'h0000_0000;
		end else begin
			state_ff  <= nxt_state;
			left_ff   <= nxt_left;
			sh_ff     <= nxt_sh;
			crc_ff    <= nxt_crc;
			result_ff <= nxt_result;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb_top @(posedge clk_sys); endclocking
	default disable iff (reset);

	wire fold = (state_ff == CRCU_ST_FOLD);

	// Fold times count from the pop; the FIFO adds a cycle when it was empty

	a_byte_fold_time: assert property (
		(pop && is_byte) |=> fold ##1 !fold)
		else $error("Byte write did not fold in one cycle");
	a_half_fold_time: assert property (
		(pop && is_half) |=> fold [*2] ##1 !fold)
		else $error("Half-word write did not fold in two cycles");
	a_word_fold_time: assert property (
		(pop && !is_byte && !is_half) |=> fold [*4] ##1 !fold)
		else $error("Word write did not fold in four cycles");
	a_poly16_value: assert property (
		(fold && !seed_load && crc_ff == 32'h0 && sh_ff[7:0] == 8'h01 && cfg.mode == `CRCU_MODE_16)
		|=> (crc_ff == `CRCU_POLY_16))
		else $error("16-bit polynomial step wrong");
	a_ccitt_value: assert property (
		(fold && !seed_load && crc_ff == 32'h0 && sh_ff[7:0] == 8'h01 && cfg.mode == `CRCU_MODE_CCITT)
		|=> (crc_ff == `CRCU_POLY_CCITT))
		else $error("CCITT polynomial step wrong");
	a_poly32_value: assert property (
		(fold && !seed_load && crc_ff == 32'h0 && sh_ff[7:0] == 8'h01 && cfg.mode == `CRCU_MODE_32)
		|=> (crc_ff == `CRCU_POLY_32))
		else $error("32-bit polynomial step wrong");
	a_seed_load_value: assert property (
		seed_load |=> (crc_ff == ($past(seed_value) & ($past(is32) ? `CRCU_MASK32 : `CRCU_MASK16))))
		else $error("Seed not loaded into accumulator");
	a_sum_cmpl_out: assert property (
		(cfg.sum_cmpl && !cfg.sum_byte_rev && !cfg.sum_bit_rev && is32)
		|=> (crc_result == ~$past(crc_ff)))
		else $error("Result complement wrong");
	a_result_width: assert property (
		(!is32 && !$past(is32)) |-> (crc_result[31:16] == 16'h0000))
		else $error("16-bit result has upper bits set");
	a_entry_held: assert property (
		(fifo_valid && !pop) |=> (fifo_valid && $stable(fifo_q)))
		else $error("Waiting entry changed or vanished");
	a_din_cmpl_load: assert property (
		(pop && cfg.din_cmpl && !cfg.din_byte_rev && !cfg.din_bit_rev) |=> (sh_ff == ~$past(fifo_q.data)))
		else $error("Data complement not applied");

	// Covers: word fold, words back to back, writer stalled, seed then byte
	c_word_fold: cover property (pop && !is_byte && !is_half);
	c_back_to_back: cover property (pop ##5 pop);
	c_stall: cover property (wr_valid && !wr_ready);
	c_seed_then_byte: cover property (seed_load ##[1:8] (pop && is_byte));
endmodule

// *** crcu_dma_model.sv ***
// Purpose: Writer model standing in for the core or DMA engine
// Assumes: Entries are pushed by the bench through push()
// Notes:   A released data bus shows the inverse of its last value
`timescale 1ns/10ps

module crcu_dma_model import crcu_pkg::*; (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// Pacing
	input  wire logic slow,
	// Write stream
	output logic      wr_valid,
	input  wire logic wr_ready,
	output crcu_wr_t  wr_req
);
	crcu_wr_t q[$];
	logic     gap_ff;

	task automatic push(input crcu_wr_t w);
		q.push_back(w);
	endtask

	// Hold until taken, then next entry in order; slow inserts idle gaps
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_valid <= 1'b0;
			wr_req   <= '0;
			gap_ff   <= 1'b0;
		end else if (wr_valid && !wr_ready) begin
			gap_ff <= gap_ff;
		end else if (q.size() > 0 && !(slow && gap_ff)) begin
			wr_valid <= 1'b1;
			wr_req   <= q.pop_front();
			gap_ff   <= 1'b1;
		end else begin
			wr_valid <= 1'b0;
			wr_req   <= ~wr_req; // Released: no stale value
			gap_ff   <= 1'b0;
		end
	end
endmodule

// *** crc_calc_unit_tb.sv ***
// Purpose: Self-checking bench for crcu_top
// Assumes: crcu_dma_model feeds the write stream
// Notes:   Reference checksum computed bit by bit, MSB first
`timescale 1ns/10ps
`include "crcu_consts.svh"

module crc_calc_unit_tb import crcu_pkg::*; ;
	logic        clk_sys, reset, seed_load, wr_valid, wr_ready, busy, slow;
	logic [31:0] seed_value, crc_result, exp_acc;
	crcu_cfg_t   cfg, cur;
	crcu_wr_t    wr_req;
	int          failures, check_count;
	int          stall_count = 0;

	crcu_top u_crcu_top (.clk_sys(clk_sys), .reset(reset), .cfg(cfg), .seed_load(seed_load),
		.seed_value(seed_value), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_req(wr_req),
		.crc_result(crc_result), .busy(busy));
	crcu_dma_model u_crcu_dma_model (.clk_sys(clk_sys), .reset(reset), .slow(slow),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_req(wr_req));

	// ****************************************
	// Reference model
	// ****************************************
	function automatic logic [31:0] fold(input logic [31:0] a, input crcu_cfg_t c, input crcu_wr_t w);
		logic [31:0] d;
		logic [31:0] p;
		logic [7:0]  b;
		int          n;
		n = (w.size == 0) ? 1 : (w.size == 1) ? 2 : 4;
		d = c.din_cmpl ? ~w.data : w.data;
		if (c.din_byte_rev && n == 2)
			d = {16'h0000, d[7:0], d[15:8]};
		if (c.din_byte_rev && n == 4)
			d = {d[7:0], d[15:8], d[23:16], d[31:24]};
		p = (c.mode == 0) ? `CRCU_POLY_16 : (c.mode == 1) ? `CRCU_POLY_CCITT : `CRCU_POLY_32;
		// Low byte first, each byte MSB first
		for (int i = 0; i < n; i++) begin
			b = d[8*i+:8];
			if (c.din_bit_rev)
				b = {<<{b}};
			for (int j = 7; j >= 0; j--)
				a = ((c.mode < 2 ? a[15] : a[31]) ^ b[j]) ? (a << 1) ^ p : a << 1;
		end
		return a & (c.mode < 2 ? `CRCU_MASK16 : `CRCU_MASK32);
	endfunction

	function automatic logic [31:0] post(input logic [31:0] a, input crcu_cfg_t c);
		logic n16;
		n16 = c.mode < 2;
		if (c.sum_cmpl)
			a = ~a & (n16 ? `CRCU_MASK16 : `CRCU_MASK32);
		if (c.sum_byte_rev)
			a = n16 ? {16'h0000, a[7:0], a[15:8]} : {a[7:0], a[15:8], a[23:16], a[31:24]};
		if (c.sum_bit_rev) begin
			a = {<<{a}};
			if (n16)
				a = a >> 16;
		end
		return a;
	endfunction

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Config change and seed on the same edge; seed masked to width
	task automatic set_cfg(input crcu_cfg_t c, input logic [31:0] s);
		@(posedge clk_sys);
		cfg        <= c;
		seed_load  <= 1'b1;
		seed_value <= s;
		cur = c;
		exp_acc = s & (c.mode < 2 ? `CRCU_MASK16 : `CRCU_MASK32);
		@(posedge clk_sys);
		seed_load <= 1'b0;
	endtask

	task automatic send(input logic [1:0] sz, input logic [31:0] d);
		u_crcu_dma_model.push({sz, d});
		exp_acc = fold(exp_acc, cur, {sz, d});
	endtask

	// Bounded wait for the stream to drain, then compare the result
	task automatic settle();
		int k;
		k = 0;
		repeat (3) @(negedge clk_sys);
		while ((busy !== 1'b0 || wr_valid !== 1'b0) && k < 400) begin
			@(negedge clk_sys);
			k++;
		end
		if (k >= 400) begin
			failures++;
			$display("FAIL t=%0t drain timed out", $time);
		end
		repeat (2) @(posedge clk_sys);
		#1 chk(crc_result, post(exp_acc, cur), "result");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			set_cfg(crcu_cfg_t'({m[1:0], 6'h00}), 32'h9ABC_DEF1);
			repeat (2) @(posedge clk_sys);
			#1 chk(crc_result, post(exp_acc, cur), "seed");
			send(2'h2, 32'h3141_5926);
			send(2'h0, 32'h0000_00A7);
			settle();
			// Byte 0x01 from a zero seed leaves exactly the polynomial
			set_cfg(crcu_cfg_t'({m[1:0], 6'h00}), 32'h0000_0000);
			send(2'h0, 32'h0000_0001);
			settle();
			chk(crc_result, (m < 2) ? ((m == 0) ? `CRCU_POLY_16 : `CRCU_POLY_CCITT) : `CRCU_POLY_32, "poly");
		end
		$display("test modes done");
	endtask

	task automatic t_sizes();
		int n;
		set_cfg(crcu_cfg_t'(8'h40), 32'h0000_FFFF);
		for (int s = 0; s < 4; s++) begin
			send(s[1:0], 32'hC001_D00D);
			repeat (6) begin
				if (busy !== 1'b1)
					@(negedge clk_sys);
			end
			n = 0;
			while (busy === 1'b1 && n < 9) begin
				@(negedge clk_sys);
				n++;
			end
			chk(32'(n), 32'((s == 3) ? 5 : (1 << s) + 1), "fold cycles");
			settle();
		end
		$display("test sizes done");
	endtask

	task automatic t_opts();
		logic [5:0] opt [7] = '{6'h38, 6'h07, 6'h2A, 6'h15, 6'h3F, 6'h1B, 6'h24};
		for (int i = 0; i < 7; i++) begin
			set_cfg(crcu_cfg_t'({i[0] ? 2'h0 : 2'h2, opt[i]}), 32'hFFFF_FFFF);
			send(2'h1, 32'h0000_1D2E);
			send(2'h2, 32'h8421_7BDE);
			settle();
		end
		$display("test options done");
	endtask

	// Back-to-back words overrun the fold rate and must be held off
	task automatic t_burst();
		int s0;
		set_cfg(crcu_cfg_t'(8'h80), 32'hFFFF_FFFF);
		s0 = stall_count;
		for (int i = 0; i < 24; i++)
			send(2'h2, 32'h0101_0101 * i);
		settle();
		chk(32'(stall_count > s0), 32'h0000_0001, "held off");
		slow <= 1'b1;
		for (int i = 0; i < 3; i++)
			send(2'h0, 32'h0000_005A + i);
		settle();
		slow <= 1'b0;
		$display("test burst done");
	endtask

	// Cycles in which the writer is held off by a full FIFO
	always @(negedge clk_sys)
		if (wr_valid === 1'b1 && wr_ready === 1'b0)
			stall_count <= stall_count + 1;

	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog and main sequence
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	initial begin
		#2_000_000;
		failures++;
		print_verdict();
	end

	initial begin
		reset = 1'b1;
		cfg = '0;
		cur = '0;
		seed_load = 1'b0;
		seed_value = '0;
		slow = 1'b0;
		failures = 0;
		check_count = 0;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		#1 chk(crc_result, `CRCU_CRC_RST, "reset value");
		t_modes();
		t_sizes();
		t_opts();
		t_burst();
		print_verdict();
	end
endmodule
